// >>> verilog/xie_consts.svh
// register map, field positions and reset values of the exclusive-OR execute block
// Overview of operation
// RULE1: register form XORs source with destination and writes result back, byte/word/long.
// RULE2: register form source is always one of eight data registers, 3-bit field.
// RULE3: register form opmode 100, 101, 110 mean byte, word, long into destination.
// RULE4: N is result msb, Z set on zero result, V and C cleared, X kept.
// RULE5: register form destination only data-alterable: 000, 010-110, 111 absolute.
// RULE6: register form never decoded as memory into data register; register is source only.
// RULE7: immediate form XORs inline data with destination, data sized as the operation.
// RULE8: immediate size field 00 byte, 01 word, 10 long.
// RULE9: immediate data: low byte of word, whole word, or next two words.
// RULE10: immediate destination data-alterable only; mode 110 indexed forms accepted.
`ifndef XIE_CONSTS_SVH
`define XIE_CONSTS_SVH
// register byte offsets; XIE_OFF_DREG is the address bits 7:5 value of the data-register window
`define XIE_OFF_CTRL 8'h00
`define XIE_OFF_STATUS 8'h04
`define XIE_OFF_OPCODE 8'h08
`define XIE_OFF_EXT0 8'h0C
`define XIE_OFF_EXT1 8'h10
`define XIE_OFF_MEMOP 8'h14
`define XIE_OFF_RESULT 8'h18
`define XIE_OFF_CCR 8'h1C
`define XIE_OFF_DREG 3'h1
// control, status and condition code bit positions
`define XIE_CTRL_START 0
`define XIE_STAT_BUSY 0
`define XIE_STAT_DONE 1
`define XIE_STAT_ILLEGAL 2
`define XIE_STAT_MEMDEST 3
`define XIE_CCR_C 0
`define XIE_CCR_V 1
`define XIE_CCR_Z 2
`define XIE_CCR_N 3
`define XIE_CCR_X 4
// opcode field positions and codes
`define XIE_F_SRC_HI 11
`define XIE_F_SRC_LO 9
`define XIE_F_OPM_HI 8
`define XIE_F_OPM_LO 6
`define XIE_F_MODE_HI 5
`define XIE_F_MODE_LO 3
`define XIE_F_REG_HI 2
`define XIE_F_REG_LO 0
`define XIE_LINE_REGFORM 4'hB
`define XIE_PREFIX_IMM 8'h0A
`define XIE_SIZE_BAD 2'h3
`define XIE_OPM_BYTE 3'h4
`define XIE_OPM_WORD 3'h5
`define XIE_OPM_LONG 3'h6
`define XIE_MODE_DREG 3'h0
`define XIE_MODE_AREG 3'h1
`define XIE_MODE_EXT 3'h7
`define XIE_EXT_ABS_W 3'h0
`define XIE_EXT_ABS_L 3'h1
// reset values
`define XIE_RST_WORD 32'h0000_0000
`define XIE_RST_HALF 16'h0000
`define XIE_RST_CCR 5'h00
`endif

// >>> verilog/xie_pkg.sv
// types shared by the exclusive-OR execute block
package xie_pkg;
  // operation size, coded as the immediate size field
  typedef enum logic [1:0] {
    XIE_SZ_BYTE = 2'b00,
    XIE_SZ_WORD = 2'b01,
    XIE_SZ_LONG = 2'b10
  } xie_size_t;
  // sequencer states
  typedef enum logic [1:0] {
    XIE_ST_IDLE = 2'b00,
    XIE_ST_DECODE = 2'b01,
    XIE_ST_EXEC = 2'b10
  } xie_state_t;
  // decoded instruction
  typedef struct packed {
    logic is_reg_form;
    logic is_imm_form;
    logic illegal;
    xie_size_t size;
    logic [2:0] src_reg;
    logic [2:0] ea_mode;
    logic [2:0] ea_reg;
    logic [31:0] imm;
  } xie_dec_t;
  // result and flags of one operation
  typedef struct packed {
    logic [31:0] merged;
    logic [31:0] sized;
    logic neg;
    logic zero;
  } xie_alu_t;
endpackage

// >>> verilog/xie_decode.sv
// opcode decoder for both exclusive-OR forms
`timescale 1ns/10ps
`include "xie_consts.svh"
module xie_decode (
  input wire logic [15:0] opcode,
  input wire logic [15:0] ext0,
  input wire logic [15:0] ext1,
  output xie_pkg::xie_dec_t dec
);
  // field split, form recognition, destination legality, immediate extraction
  always_comb begin
    logic ea_ok;
    logic [2:0] opm;
    ea_ok = 1'b0;
    opm = opcode[`XIE_F_OPM_HI:`XIE_F_OPM_LO];
    dec = '0;
    dec.src_reg = opcode[`XIE_F_SRC_HI:`XIE_F_SRC_LO]; // RULE2
    dec.ea_mode = opcode[`XIE_F_MODE_HI:`XIE_F_MODE_LO];
    dec.ea_reg = opcode[`XIE_F_REG_HI:`XIE_F_REG_LO];
    // data-alterable destinations only
    case (dec.ea_mode)
      `XIE_MODE_DREG: ea_ok = 1'b1; // RULE5
      `XIE_MODE_AREG: ea_ok = 1'b0; // RULE5 RULE10
      `XIE_MODE_EXT: ea_ok = (dec.ea_reg == `XIE_EXT_ABS_W) ||
                             (dec.ea_reg == `XIE_EXT_ABS_L); // RULE5 RULE10
      default: ea_ok = 1'b1; // RULE10
    endcase
    // register form: only the ea-destination opmodes count
    if (opcode[15:12] == `XIE_LINE_REGFORM) begin
      case (opm)
        `XIE_OPM_BYTE, `XIE_OPM_WORD, `XIE_OPM_LONG: begin
          dec.is_reg_form = 1'b1; // RULE3 RULE6
          dec.size = xie_pkg::xie_size_t'(opm[1:0]); // RULE3
        end
        default: dec.is_reg_form = 1'b0; // RULE6
      endcase
    end
    // immediate form with size field in bits 7:6
    if (opcode[15:8] == `XIE_PREFIX_IMM && opcode[7:6] != `XIE_SIZE_BAD) begin
      dec.is_imm_form = 1'b1;
      dec.size = xie_pkg::xie_size_t'(opcode[7:6]); // RULE8
    end
    // immediate operand taken from the extension words
    case (dec.size)
      xie_pkg::XIE_SZ_BYTE: dec.imm = {24'h00_0000, ext0[7:0]}; // RULE9
      xie_pkg::XIE_SZ_WORD: dec.imm = {16'h0000, ext0}; // RULE9
      default: dec.imm = {ext0, ext1}; // RULE9
    endcase
    dec.illegal = !(dec.is_reg_form || dec.is_imm_form) || !ea_ok;
  end
endmodule

// >>> verilog/xie_alu.sv
// sized exclusive-OR with negative and zero flags
`timescale 1ns/10ps
module xie_alu (
  input wire logic [31:0] src,
  input wire logic [31:0] dst,
  input wire xie_pkg::xie_size_t size,
  output xie_pkg::xie_alu_t res
);
  logic [31:0] x;
  // bitwise xor of both operands
  assign x = src ^ dst; // RULE1 RULE7
  // size selects the live bits; merged keeps untouched upper destination bits
  always_comb begin
    res = '0;
    case (size)
      xie_pkg::XIE_SZ_BYTE: begin
        res.sized = {24'h00_0000, x[7:0]};
        res.merged = {dst[31:8], x[7:0]};
        res.neg = x[7]; // RULE4
        res.zero = (x[7:0] == 8'h00); // RULE4
      end
      xie_pkg::XIE_SZ_WORD: begin
        res.sized = {16'h0000, x[15:0]};
        res.merged = {dst[31:16], x[15:0]};
        res.neg = x[15]; // RULE4
        res.zero = (x[15:0] == 16'h0000); // RULE4
      end
      default: begin
        res.sized = x;
        res.merged = x;
        res.neg = x[31]; // RULE4
        res.zero = (x == 32'h0000_0000); // RULE4
      end
    endcase
  end
endmodule

// >>> verilog/xie_top.sv
// exclusive-OR execute block with its Avalon-MM register slave
`timescale 1ns/10ps
`include "xie_consts.svh"
module xie_top #(
  parameter int ADDR_W = 8
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic exec_busy,
  output logic illegal_trap
);

  // architectural and staging registers
  logic [31:0] dreg_q [0:7];
  logic [15:0] opcode_q;
  logic [15:0] ext0_q;
  logic [15:0] ext1_q;
  logic [31:0] memop_q;
  logic [31:0] result_q;
  logic [4:0] ccr_q;
  logic busy_q;
  logic done_q;
  logic illegal_q;
  logic memdest_q;
  xie_pkg::xie_state_t state_q;
  xie_pkg::xie_state_t state_d;
  xie_pkg::xie_dec_t dec_w;
  xie_pkg::xie_dec_t dec_q;
  xie_pkg::xie_alu_t alu_w;

  // bus slave state
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic req;
  logic acc;
  logic wr_ok;
  logic start;
  logic [7:0] addr;
  logic [31:0] src_val;
  logic [31:0] dst_val;
  logic exec_now;

  // byte-enable merge of a write into a stored word
  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // request handshake terms; a transfer completes when waitrequest is seen low
  assign addr = 8'(avs_address);
  assign req = avs_read || avs_write;
  assign acc = req && !wait_q;
  assign wr_ok = acc && avs_write && !busy_q; // writes refused while busy
  assign start = wr_ok && addr == `XIE_OFF_CTRL && avs_byteenable[0] &&
                 avs_writedata[`XIE_CTRL_START];
  assign exec_now = (state_q == xie_pkg::XIE_ST_EXEC);

  // waitrequest drops one cycle after a request arrives and rises after the transfer
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wait_q <= 1'b1;
    end else if (acc) begin
      wait_q <= 1'b1;
    end else if (req) begin
      wait_q <= 1'b0;
    end
  end

  // read data is captured when waitrequest is dropped and held through the transfer
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= `XIE_RST_WORD;
    end else if (req && wait_q && avs_read) begin
      rdata_q <= rdata_d;
    end
  end

  // read-back mux; unmapped offsets read as zero
  always_comb begin
    rdata_d = `XIE_RST_WORD;
    if (addr[7:5] == `XIE_OFF_DREG) begin
      rdata_d = dreg_q[addr[4:2]];
    end else begin
      case ({addr[7:2], 2'b00})
        `XIE_OFF_STATUS: begin
          rdata_d[`XIE_STAT_BUSY] = busy_q;
          rdata_d[`XIE_STAT_DONE] = done_q;
          rdata_d[`XIE_STAT_ILLEGAL] = illegal_q;
          rdata_d[`XIE_STAT_MEMDEST] = memdest_q;
        end
        `XIE_OFF_OPCODE: rdata_d = {16'h0000, opcode_q};
        `XIE_OFF_EXT0: rdata_d = {16'h0000, ext0_q};
        `XIE_OFF_EXT1: rdata_d = {16'h0000, ext1_q};
        `XIE_OFF_MEMOP: rdata_d = memop_q;
        `XIE_OFF_RESULT: rdata_d = result_q;
        `XIE_OFF_CCR: rdata_d = {27'h000_0000, ccr_q};
        default: rdata_d = `XIE_RST_WORD;
      endcase
    end
  end

  // instruction staging registers written by software
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      opcode_q <= `XIE_RST_HALF;
      ext0_q <= `XIE_RST_HALF;
      ext1_q <= `XIE_RST_HALF;
      memop_q <= `XIE_RST_WORD;
    end else if (wr_ok) begin
      case ({addr[7:2], 2'b00})
        `XIE_OFF_OPCODE: opcode_q <= 16'(be_merge({16'h0000, opcode_q},
                                                  avs_writedata, avs_byteenable));
        `XIE_OFF_EXT0: ext0_q <= 16'(be_merge({16'h0000, ext0_q},
                                              avs_writedata, avs_byteenable));
        `XIE_OFF_EXT1: ext1_q <= 16'(be_merge({16'h0000, ext1_q},
                                              avs_writedata, avs_byteenable));
        `XIE_OFF_MEMOP: memop_q <= be_merge(memop_q, avs_writedata, avs_byteenable);
        default: ;
      endcase
    end
  end

  // decoder and operation unit
  xie_decode u_decode (
    .opcode(opcode_q),
    .ext0(ext0_q),
    .ext1(ext1_q),
    .dec(dec_w)
  );

  // source is a data register for the register form, the immediate otherwise
  assign src_val = dec_q.is_reg_form ? dreg_q[dec_q.src_reg] : dec_q.imm; // RULE2 RULE7
  // destination is a data register in mode 000, else the staged memory operand
  assign dst_val = (dec_q.ea_mode == `XIE_MODE_DREG) ? dreg_q[dec_q.ea_reg] : memop_q;

  xie_alu u_alu (
    .src(src_val),
    .dst(dst_val),
    .size(dec_q.size),
    .res(alu_w)
  );

  // sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      xie_pkg::XIE_ST_IDLE: begin
        if (start) begin
          state_d = xie_pkg::XIE_ST_DECODE;
        end
      end
      xie_pkg::XIE_ST_DECODE: begin
        state_d = dec_w.illegal ? xie_pkg::XIE_ST_IDLE : xie_pkg::XIE_ST_EXEC;
      end
      xie_pkg::XIE_ST_EXEC: state_d = xie_pkg::XIE_ST_IDLE;
      default: state_d = xie_pkg::XIE_ST_IDLE;
    endcase
  end

  // sequencer state register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= xie_pkg::XIE_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // decoded instruction is frozen for the execute cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dec_q <= '0;
    end else if (state_q == xie_pkg::XIE_ST_DECODE) begin
      dec_q <= dec_w;
    end
  end

  // busy, done and illegal status; start only happens while idle so set and clear never meet
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      if (start) begin
        busy_q <= 1'b1;
        done_q <= 1'b0;
        illegal_q <= 1'b0;
      end else if (state_q == xie_pkg::XIE_ST_DECODE && dec_w.illegal) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
        illegal_q <= 1'b1; // RULE5 RULE6 RULE10
      end else if (exec_now) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end

  // result word and memory-destination marker
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      result_q <= `XIE_RST_WORD;
      memdest_q <= 1'b0;
    end else if (exec_now) begin
      result_q <= alu_w.sized; // RULE1 RULE7
      memdest_q <= (dec_q.ea_mode != `XIE_MODE_DREG);
    end
  end

  // condition codes: software may load them; execution sets N and Z, clears V and C
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ccr_q <= `XIE_RST_CCR;
    end else if (exec_now) begin
      ccr_q[`XIE_CCR_N] <= alu_w.neg; // RULE4
      ccr_q[`XIE_CCR_Z] <= alu_w.zero; // RULE4
      ccr_q[`XIE_CCR_V] <= 1'b0; // RULE4
      ccr_q[`XIE_CCR_C] <= 1'b0; // RULE4
    end else if (wr_ok && addr == `XIE_OFF_CCR && avs_byteenable[0]) begin
      ccr_q <= avs_writedata[4:0];
    end
  end

  // data registers: written back on a data-register destination, else by software
  for (genvar i = 0; i < 8; i++) begin : g_dreg
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        dreg_q[i] <= `XIE_RST_WORD;
      end else if (exec_now && dec_q.ea_mode == `XIE_MODE_DREG &&
                   dec_q.ea_reg == 3'(i)) begin
        dreg_q[i] <= alu_w.merged; // RULE1 RULE7
      end else if (wr_ok && addr[7:5] == `XIE_OFF_DREG && addr[4:2] == 3'(i)) begin
        dreg_q[i] <= be_merge(dreg_q[i], avs_writedata, avs_byteenable);
      end
    end
  end

  // outputs come straight from flip-flops
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign exec_busy = busy_q;
  assign illegal_trap = illegal_q;

endmodule

// >>> sim/xie_props.sv
// port assertions for the exclusive-OR execute block
`timescale 1ns/10ps
module xie_props #(
  parameter int ADDR_W = 8
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic exec_busy,
  input wire logic illegal_trap
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // bus answers after exactly one wait cycle, then waits again
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  idle_wait_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low without a request");
  rdata_hold_a: assert property (!$stable(avs_readdata) |-> $past(avs_read) && $past(avs_waitrequest))
    else $error("read data changed outside a read");
  // start write to control while idle launches execution
  start_busy_a: assert property (avs_write && !avs_waitrequest && avs_address[ADDR_W-1:2] == '0
    && avs_writedata[0] && avs_byteenable[0] && !exec_busy |=> exec_busy)
    else $error("start did not raise busy");
  busy_len_a: assert property ($rose(exec_busy) |-> ##[1:2] !exec_busy)
    else $error("execution took too long");
  trap_end_a: assert property ($rose(illegal_trap) |-> $fell(exec_busy))
    else $error("trap raised outside the end of an operation");
  trap_clear_a: assert property ($fell(illegal_trap) |-> exec_busy)
    else $error("trap cleared without a new start");
endmodule

// >>> sim/tb_xor_instruction_exec.sv
// self-checking bench for the exclusive-OR execute block
`timescale 1ns/10ps
module tb_xor_instruction_exec;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, q, d, s, m, r, imm;
  logic avs_waitrequest, exec_busy, illegal_trap;
  logic [5:0] ea;
  logic [15:0] illegal_ops [8] = '{16'hB148, 16'hB002, 16'hB17C, 16'hB17A,
    16'h0AC0, 16'h0A48, 16'h0A7B, 16'h0A3C};
  int err_total = 0;
  int samples_checked = 0;
  // free-running core clock
  always #12.5 mclk = ~mclk;
  xie_top #(.ADDR_W(8)) dut_u (.mclk(mclk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .exec_busy(exec_busy), .illegal_trap(illegal_trap));
  // verdict and end of run
  task wrap_up;
    if (err_total == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one bus transfer, held until waitrequest is sampled low
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    avs_byteenable <= be;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 40)
      err_total++;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd, 4'hF);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(q, exp);
  endtask
  // load operands, set all flags, start and poll until done
  task run(input logic [15:0] op, input logic [31:0] ex, input logic [31:0] mem);
    int n;
    wr(8'h08, {16'h0, op});
    wr(8'h0C, {16'h0, ex[31:16]});
    wr(8'h10, {16'h0, ex[15:0]});
    wr(8'h14, mem);
    wr(8'h1C, 32'h1F);
    wr(8'h00, 32'h1);
    n = 0;
    do begin
      bus(1'b0, 8'h04, 32'h0, 4'hF);
      n++;
    end while (q[1] !== 1'b1 && n < 20);
    // a poll that never sees done counts as a mismatch
    if (n >= 20)
      err_total++;
  endtask
  function automatic logic [31:0] msk(input int sz);
    return sz == 0 ? 32'hFF : (sz == 1 ? 32'hFFFF : 32'hFFFF_FFFF);
  endfunction
  // expected flags: X kept set, N from sized msb, Z on zero, V and C clear
  function automatic logic [31:0] ccr(input logic [31:0] v, input int sz);
    logic n;
    n = v[sz == 0 ? 7 : (sz == 1 ? 15 : 31)];
    return {27'h0, 1'b1, n, v == 32'h0, 2'b00};
  endfunction
  // main sequence
  initial begin
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    rd(8'h04, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h1C, 32'h0);
    rd(8'h28, 32'h0);
    s = 32'hF0F0_8081;
    d = 32'h0F0F_7F81;
    wr(8'h34, s);
    wr(8'h28, d);
    // register form into a data register, all three sizes
    for (int sz = 0; sz < 3; sz++) begin
      run({4'hB, 3'h5, 3'(4 + sz), 6'h02}, 32'h0, 32'h0);
      chk(q, 32'h2);
      r = (s ^ d) & msk(sz);
      d = (d & ~msk(sz)) | r;
      rd(8'h28, d);
      rd(8'h34, s);
      rd(8'h1C, ccr(r, sz));
    end
    // immediate form into memory destinations
    m = 32'h8000_00FF;
    for (int sz = 0; sz < 3; sz++) begin
      ea = sz == 0 ? 6'h30 : (sz == 1 ? 6'h11 : 6'h39);
      imm = 32'h12FF_5678 >> (sz == 2 ? 0 : 16);
      run({8'h0A, 2'(sz), ea}, 32'h12FF_5678, m);
      chk(q, 32'hA);
      r = (imm ^ m) & msk(sz);
      rd(8'h18, r);
      rd(8'h1C, ccr(r, sz));
    end
    // read-only, unmapped and byte-lane accesses
    wr(8'h18, 32'h5555_5555);
    rd(8'h18, r);
    rd(8'h40, 32'h0);
    rd(8'h00, 32'h0);
    bus(1'b1, 8'h2C, 32'hAAAA_BBBB, 4'h3);
    rd(8'h2C, 32'h0000_BBBB);
    // illegal encodings trap and leave the data register alone
    for (int i = 0; i < 8; i++) begin
      run(illegal_ops[i], 32'h12FF_5678, m);
      // memdest stays from the last executed long memory op; a trap leaves it alone
      chk(q, 32'hE);
      chk({31'h0, illegal_trap}, 32'h1);
      rd(8'h28, d);
    end
    wrap_up;
  end
  // watchdog against a hung handshake
  initial begin
    #500000;
    err_total++;
    wrap_up;
  end
endmodule
bind xie_top xie_props #(.ADDR_W(ADDR_W)) props_u (.mclk(mclk), .resetn(resetn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .exec_busy(exec_busy), .illegal_trap(illegal_trap));
